// >>> src/ecppc_top.sv
// Control, configuration and FIFO modes of the extended parallel port.
// Assumes a host port of single-cycle rd/wr strobes decoded from the base,
// and printer pins from outside the clock domain.
// Operation
// - Control register bits 7 and 6 read as one; writes ignored.
// - Direction bit ignored in modes 000 and 010; else 0 out, 1 in.
// - With ack enable set, each rising acknowledge edge requests an interrupt.
// - Select control bit drives select pin inverted; one selects printer.
// - Initialise control bit drives the initialise pin without inversion.
// - Auto line feed bit drives the line feed pin inverted outside ECP mode.
// - Strobe bit drives the strobe pin inverted outside modes 010 and 011.
// - Mode 010 sends FIFO bytes out with automatic standard handshake.
// - ECP mode, direction zero, sends FIFO bytes with ECP handshake.
// - ECP mode, direction one, fills FIFO from peripheral; host reads them.
// - Test mode: host reads and writes FIFO; FIFO head on data lines, no handshake.
// - Configuration register A reads fixed eight-bit identifier value.
// - Configuration B compression bit reads zero, read-only.
// - Configuration B bit 6 returns present interrupt line level.
// - Configuration B bits 5 to 3 report the assigned interrupt.
// - Configuration B bits 2 to 0 read as ones; writes ignored.
// - Extended control resets to mode 0, fault disable 1, service 1, empty 1.
// - Mode 000 holds the FIFO in reset.
// - Configuration registers at 0x400 and 0x401 only in configuration mode.
// - All FIFO views share one sixteen-byte FIFO.
`timescale 1ns/10ps
`include "ecppc_consts.svh"
module ecppc_top import ecppc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [10:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] pd_i,
  output logic [7:0] pd_o,
  output logic pd_oe_n_o,
  output logic strobe_pin_o,
  output logic linefeed_pin_o,
  output logic printer_reset_ctl_o,
  output logic printer_select_pin_o,
  input wire logic ack_n_i,
  input wire logic busy_i,
  input wire logic perror_i,
  input wire logic select_i,
  input wire logic fault_n_i,
  input wire logic irq_line_i,
  input wire logic [2:0] irq_sel_i,
  output logic irq_o
);
  localparam int SYN = 14;
  localparam logic [4:0] SETUP_LD = 5'(`ECPPC_SETUP_CYC - 1);
  localparam logic [4:0] STROBE_LD = 5'(`ECPPC_STROBE_CYC - 1);
  localparam logic [4:0] FIFO_FULL = 5'(`ECPPC_FIFO_DEPTH);

  logic [SYN-1:0] syn1_r;
  logic [SYN-1:0] syn2_r;
  logic [7:0] pd_s;
  logic ack_s, busy_s, perror_s, select_s, fault_s, irql_s;
  logic ack_q_r;
  logic [7:0] data_r;
  logic [5:0] dcr_r;
  logic [2:0] mode_r;
  logic fault_irq_disable_r, dma_enable_bit_r, service_request_r;
  ecppc_hs_state_t hs_st_r;
  logic [4:0] cnt_r;
  logic hs_stb_act_r, hs_afd_pin_r;
  logic [7:0] hs_data_r;
  logic dir_in, hs_mode, ecp_fwd, ecp_rev;
  logic host_push, host_pop, hs_push, hs_pop;
  logic fifo_full, fifo_empty;
  logic [7:0] rd_nxt, pd_nxt;
  logic stb_nxt, afd_nxt;
  logic [5:0] std_age_r;

  ecppc_fifo_if #(.W(`ECPPC_FIFO_WIDTH), .CW(5)) fif ();

  // One FIFO serves every FIFO view
  ecppc_fifo #(.W(`ECPPC_FIFO_WIDTH), .D(`ECPPC_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .f(fif.buf_side)
  );

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers reset to idle pin levels; only stage two feeds logic
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      syn1_r <= 14'h0022; // Ack and fault idle high, so no false edge after reset
      syn2_r <= 14'h0022;
    end else begin
      syn1_r <= {pd_i, ack_n_i, busy_i, perror_i, select_i, fault_n_i, irq_line_i};
      syn2_r <= syn1_r;
    end
  end
  assign {pd_s, ack_s, busy_s, perror_s, select_s, fault_s, irql_s} = syn2_r;

  // Mode decode shared by data path and sequencer
  assign dir_in = dcr_r[`ECPPC_DCR_DIR] && (mode_r != `ECPPC_MODE_SPP)
                  && (mode_r != `ECPPC_MODE_FIFO);
  assign hs_mode = (mode_r == `ECPPC_MODE_FIFO) || (mode_r == `ECPPC_MODE_ECP);
  assign ecp_fwd = (mode_r == `ECPPC_MODE_ECP) && !dir_in;
  assign ecp_rev = (mode_r == `ECPPC_MODE_ECP) && dir_in;
  assign fifo_full = (fif.count == FIFO_FULL);
  assign fifo_empty = (fif.count == 5'h00);

  ////////////////////////////////////////////////////////////////////
  // FIFO push and pop; address writes carry a tag in bit 8
  assign host_push = wr_i && (((addr_i == `ECPPC_OFF_FIFO)
                     && ((mode_r == `ECPPC_MODE_FIFO) || ecp_fwd
                     || (mode_r == `ECPPC_MODE_TEST)))
                     || ((addr_i == `ECPPC_OFF_DATA) && ecp_fwd));
  assign host_pop = rd_i && (addr_i == `ECPPC_OFF_FIFO) && fif.pop_valid
                    && (ecp_rev || (mode_r == `ECPPC_MODE_TEST));
  assign hs_pop = (hs_st_r == hs_idle) && fif.pop_valid
                  && (((mode_r == `ECPPC_MODE_FIFO) && !busy_s) || ecp_fwd);
  assign hs_push = (hs_st_r == hs_idle) && ecp_rev && !ack_s && fif.push_ready;
  assign fif.push_valid = host_push || hs_push;
  assign fif.push_data = hs_push ? {1'b0, pd_s}
                         : {(addr_i == `ECPPC_OFF_DATA), wdata_i};
  assign fif.pop_ready = host_pop || hs_pop;
  assign fif.clr = (mode_r == `ECPPC_MODE_SPP);

  ////////////////////////////////////////////////////////////////////
  // Host writes; unknown offsets and read-only fields are dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_r <= 8'h00;
      dcr_r <= 6'h00;
      {mode_r, fault_irq_disable_r, dma_enable_bit_r, service_request_r}
        <= 6'(`ECPPC_ECR_RST >> 2);
    end else if (wr_i) begin
      if (addr_i == `ECPPC_OFF_DATA) begin
        if ((mode_r == `ECPPC_MODE_SPP) || (mode_r == `ECPPC_MODE_PS2)) begin
          data_r <= wdata_i;
        end
      end else if (addr_i == `ECPPC_OFF_DCR) begin
        dcr_r <= wdata_i[5:0];
      end else if (addr_i == `ECPPC_OFF_ECR) begin
        {mode_r, fault_irq_disable_r, dma_enable_bit_r, service_request_r}
          <= wdata_i[7:2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; configuration offsets only decode in configuration mode
  always_comb begin
    rd_nxt = 8'h00;
    if (addr_i == `ECPPC_OFF_DATA) begin
      rd_nxt = pd_s;
    end else if (addr_i == `ECPPC_OFF_DSR) begin
      rd_nxt = {!busy_s, ack_s, perror_s, select_s, fault_s, 3'h7};
    end else if (addr_i == `ECPPC_OFF_DCR) begin
      rd_nxt = {`ECPPC_DCR_FIXED, dcr_r};
    end else if ((addr_i == `ECPPC_OFF_FIFO) && (mode_r == `ECPPC_MODE_CFG)) begin
      rd_nxt = `ECPPC_CFGA_VAL;
    end else if (addr_i == `ECPPC_OFF_FIFO) begin
      rd_nxt = host_pop ? fif.pop_data[7:0] : 8'h00;
    end else if ((addr_i == `ECPPC_OFF_CFGB) && (mode_r == `ECPPC_MODE_CFG)) begin
      rd_nxt = {1'b0, irql_s, irq_sel_i, `ECPPC_CFGB_LOW};
    end else if (addr_i == `ECPPC_OFF_ECR) begin
      rd_nxt = {mode_r, fault_irq_disable_r, dma_enable_bit_r,
                service_request_r, fifo_full, fifo_empty};
    end
  end

  // Read data stands from the cycle after rd_i until the next read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Handshake sequencer; leaving modes 010 and 011 aborts any transfer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_st_r <= hs_idle;
      cnt_r <= 5'h00;
      hs_stb_act_r <= 1'b0;
      hs_afd_pin_r <= 1'b1;
      hs_data_r <= 8'h00;
    end else if (!hs_mode) begin
      hs_st_r <= hs_idle;
      hs_stb_act_r <= 1'b0;
      hs_afd_pin_r <= 1'b1;
    end else begin
      case (hs_st_r)
        hs_idle: begin
          if (hs_pop) begin
            hs_data_r <= fif.pop_data[7:0];
            if (mode_r == `ECPPC_MODE_FIFO) begin
              cnt_r <= SETUP_LD;
              hs_st_r <= hs_setup;
            end else begin
              hs_afd_pin_r <= !fif.pop_data[8];
              hs_stb_act_r <= 1'b1;
              hs_st_r <= hs_ecp_ack;
            end
          end else if (hs_push) begin
            hs_afd_pin_r <= 1'b1;
            hs_st_r <= hs_rev_ack;
          end else begin
            hs_afd_pin_r <= !ecp_rev; // Low tells peripheral we can take data
          end
        end
        hs_setup: begin
          if (cnt_r == 5'h00) begin
            hs_stb_act_r <= 1'b1;
            cnt_r <= STROBE_LD;
            hs_st_r <= hs_strobe;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        hs_strobe: begin
          if (cnt_r == 5'h00) begin
            hs_stb_act_r <= 1'b0;
            cnt_r <= SETUP_LD;
            hs_st_r <= hs_hold;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        hs_hold: begin
          // Hold gives the printer time to raise busy before next byte
          if (cnt_r == 5'h00) begin
            hs_st_r <= hs_idle;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        hs_ecp_ack: begin
          if (busy_s) begin
            hs_stb_act_r <= 1'b0;
            hs_st_r <= hs_ecp_done;
          end
        end
        hs_ecp_done: begin
          if (!busy_s) begin
            hs_afd_pin_r <= 1'b1;
            hs_st_r <= hs_idle;
          end
        end
        hs_rev_ack: begin
          if (ack_s) begin
            hs_st_r <= hs_idle;
          end
        end
        default: hs_st_r <= hs_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drive; control pins follow the control register outside FIFO modes
  always_comb begin
    stb_nxt = hs_mode ? !hs_stb_act_r : !dcr_r[`ECPPC_DCR_STB];
    afd_nxt = (mode_r == `ECPPC_MODE_ECP) ? hs_afd_pin_r
              : !dcr_r[`ECPPC_DCR_AFD];
    if (hs_mode) begin
      pd_nxt = hs_data_r;
    end else if (mode_r == `ECPPC_MODE_TEST) begin
      pd_nxt = fif.pop_data[7:0];
    end else begin
      pd_nxt = data_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_o <= 8'h00;
      pd_oe_n_o <= 1'b0;
      strobe_pin_o <= 1'b1;
      linefeed_pin_o <= 1'b1;
      printer_reset_ctl_o <= 1'b0;
      printer_select_pin_o <= 1'b1;
    end else begin
      pd_o <= pd_nxt;
      pd_oe_n_o <= dir_in;
      strobe_pin_o <= stb_nxt;
      linefeed_pin_o <= afd_nxt;
      printer_reset_ctl_o <= dcr_r[`ECPPC_DCR_INIT];
      printer_select_pin_o <= !dcr_r[`ECPPC_DCR_SEL];
    end
  end

  // Acknowledge edge request, one cycle per rising edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q_r <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      ack_q_r <= ack_s;
      irq_o <= ack_s && !ack_q_r && dcr_r[`ECPPC_DCR_ACKIE];
    end
  end

  // Cycles since a standard-mode pop; the strobe timing check reads it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) std_age_r <= 6'h00;
    else if (mode_r != `ECPPC_MODE_FIFO) std_age_r <= 6'h00;
    else if (hs_pop) std_age_r <= 6'h01;
    else if (std_age_r != 6'h3f && std_age_r != 6'h00) std_age_r <= std_age_r + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_dcr_top_ones: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == `ECPPC_OFF_DCR) |=> rdata_o[7:6] == 2'h3)
    else $error("control register top bits not one");
  chk_dir_forced_out: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_r == `ECPPC_MODE_SPP) || (mode_r == `ECPPC_MODE_FIFO) |=> !pd_oe_n_o)
    else $error("data lines not driven in forced output mode");
  chk_ack_irq_edge: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(ack_s) && dcr_r[`ECPPC_DCR_ACKIE] |=> irq_o ##1 !irq_o)
    else $error("acknowledge edge request wrong");
  chk_ctl_pin_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && (addr_i == `ECPPC_OFF_DCR) && (mode_r == `ECPPC_MODE_SPP)
    ##1 (mode_r == `ECPPC_MODE_SPP) |=> {printer_select_pin_o, printer_reset_ctl_o,
    linefeed_pin_o, strobe_pin_o} == {~$past(wdata_i[3], 2), $past(wdata_i[2], 2),
    ~$past(wdata_i[1], 2), ~$past(wdata_i[0], 2)})
    else $error("control pins do not follow control register");
  chk_std_strobe_time: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (std_age_r == 6'h16) |-> !strobe_pin_o)
    else $error("standard strobe late");
  chk_ecp_fwd_strobe: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hs_pop && ecp_fwd ##1 ecp_fwd |=> !strobe_pin_o)
    else $error("ECP forward strobe missing");
  chk_ecp_rev_fill: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hs_push && !host_pop |=> fif.count == $past(fif.count) + 5'h01)
    else $error("reverse byte not captured");
  chk_test_no_send: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_r == `ECPPC_MODE_TEST) |=> hs_st_r == hs_idle)
    else $error("test mode started a transfer");
  chk_cfga_value: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == `ECPPC_OFF_FIFO) && (mode_r == `ECPPC_MODE_CFG)
    |=> rdata_o == `ECPPC_CFGA_VAL)
    else $error("configuration A value wrong");
  chk_cfgb_fields: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == `ECPPC_OFF_CFGB) && (mode_r == `ECPPC_MODE_CFG)
    |=> rdata_o == {1'b0, $past(irql_s), $past(irq_sel_i), 3'h7})
    else $error("configuration B fields wrong");
  chk_spp_fifo_flush: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_r == `ECPPC_MODE_SPP) |=> fif.count == 5'h00)
    else $error("FIFO not held in reset");
  chk_fifo_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == `ECPPC_OFF_ECR) |=> rdata_o[1:0]
    == {$past(fif.count) == 5'h10, $past(fif.count) == 5'h00})
    else $error("FIFO flags wrong");
endmodule // ecppc_top

// >>> src/ecppc_consts.svh
// Offsets, field positions, reset values and timing counts of the port.
// Assumes an includer that uses the names as sized constants.
`ifndef ECPPC_CONSTS_SVH
`define ECPPC_CONSTS_SVH
// Register offsets from the port base
`define ECPPC_OFF_DATA 11'h000
`define ECPPC_OFF_DSR 11'h001
`define ECPPC_OFF_DCR 11'h002
`define ECPPC_OFF_FIFO 11'h400
`define ECPPC_OFF_CFGB 11'h401
`define ECPPC_OFF_ECR 11'h402
// Mode field codes
`define ECPPC_MODE_SPP 3'h0
`define ECPPC_MODE_PS2 3'h1
`define ECPPC_MODE_FIFO 3'h2
`define ECPPC_MODE_ECP 3'h3
`define ECPPC_MODE_TEST 3'h6
`define ECPPC_MODE_CFG 3'h7
// Device control field positions
`define ECPPC_DCR_DIR 5
`define ECPPC_DCR_ACKIE 4
`define ECPPC_DCR_SEL 3
`define ECPPC_DCR_INIT 2
`define ECPPC_DCR_AFD 1
`define ECPPC_DCR_STB 0
// Fixed and reset values
`define ECPPC_DCR_FIXED 2'h3
`define ECPPC_CFGA_VAL 8'h10
`define ECPPC_CFGB_LOW 3'h7
`define ECPPC_ECR_RST 8'h15
// FIFO shape: byte plus address tag
`define ECPPC_FIFO_DEPTH 16
`define ECPPC_FIFO_WIDTH 9
// Timing of the standard-protocol strobe
`define ECPPC_CLK_MHZ 40
`define ECPPC_SETUP_NS 500
`define ECPPC_STROBE_NS 500
`define ECPPC_SETUP_CYC ((`ECPPC_SETUP_NS * `ECPPC_CLK_MHZ + 999) / 1000)
`define ECPPC_STROBE_CYC ((`ECPPC_STROBE_NS * `ECPPC_CLK_MHZ + 999) / 1000)
`endif

// >>> src/ecppc_pkg.sv
// Types shared by the parallel port control logic.
// Assumes nothing beyond a SystemVerilog compiler.
package ecppc_pkg;
  // Wire-level handshake sequencer
  typedef enum logic [2:0] {
    hs_idle,
    hs_setup,
    hs_strobe,
    hs_hold,
    hs_ecp_ack,
    hs_ecp_done,
    hs_rev_ack
  } ecppc_hs_state_t;
endpackage

// >>> src/ecppc_fifo_if.sv
// Push and pop channels of the shared byte FIFO.
// Assumes one clock domain on both sides.
`timescale 1ns/10ps
interface ecppc_fifo_if #(
  parameter int W = 9,
  parameter int CW = 5
);
  logic clr;
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [CW-1:0] count;
  modport src (output clr, push_valid, push_data, pop_ready,
               input push_ready, pop_valid, pop_data, count);
  modport buf_side (input clr, push_valid, push_data, pop_ready,
                    output push_ready, pop_valid, pop_data, count);
endinterface

// >>> src/ecppc_fifo.sv
// Shared first-word-fall-through FIFO with valid and ready on both sides.
// Assumes the user holds clr while the FIFO must stay empty.
`timescale 1ns/10ps
module ecppc_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ecppc_fifo_if.buf_side f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic do_push;
  logic do_pop;

  // Flags from the occupancy count, both held low while clr is set
  assign f.push_ready = (count_r != (AW+1)'(D)) && !f.clr;
  assign f.pop_valid = (count_r != '0) && !f.clr;
  assign f.pop_data = mem[rptr_r];
  assign f.count = count_r;
  assign do_push = f.push_valid && f.push_ready;
  assign do_pop = f.pop_ready && f.pop_valid;

  ////////////////////////////////////////////////////////////////////
  // Storage needs no reset; only the pointers define content
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr_r] <= f.push_data;
    end
  end

  // Pointers and count; clear wins over any transfer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else if (f.clr) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push) wptr_r <= wptr_r + 1'b1;
      if (do_pop) rptr_r <= rptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // ecppc_fifo

// >>> dv/ecppc_printer_model.sv
// Printer-side model: answers strobes with busy, sends reverse bytes.
// Assumes the bench clock and the pin levels of the port under test.
`timescale 1ns/10ps
module ecppc_printer_model (
  input wire logic clk_i,
  input wire logic strobe_n_i,
  input wire logic linefeed_n_i,
  input wire logic [7:0] dev_pd_i,
  input wire logic dev_oe_n_i,
  output logic [7:0] pd_o,
  output logic ack_n_o,
  output logic busy_o
);
  int lag = 2;
  int low_cnt = 0;
  int stb_w = 0;
  logic [7:0] drv = 8'h00;
  logic [8:0] got_q[$];
  initial begin
    ack_n_o = 1'b1;
    busy_o = 1'b0;
  end
  // Released lines show the byte on offer, then its inverse, never a stale copy
  assign pd_o = dev_oe_n_i ? drv : dev_pd_i;
  ////////////////////////////////////////////////////////////////////////
  // Latch byte and tag at strobe; busy trails strobe by lag cycles
  always begin
    @(posedge clk_i);
    if (strobe_n_i === 1'b0) begin
      got_q.push_back({~linefeed_n_i, dev_pd_i});
      repeat (lag) @(posedge clk_i);
      busy_o <= 1'b1;
      while (strobe_n_i !== 1'b1) @(posedge clk_i);
      repeat (lag) @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
  // Strobe width in cycles, kept for the timing check
  always @(posedge clk_i) begin
    if (strobe_n_i === 1'b0) low_cnt <= low_cnt + 1;
    else if (low_cnt != 0) begin
      stb_w <= low_cnt;
      low_cnt <= 0;
    end
  end
  task automatic pulse_ack();
    @(posedge clk_i);
    ack_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    ack_n_o <= 1'b1;
  endtask
  // Reverse byte: wait for ready, offer data with ack, release on reply
  task automatic send_rev(input logic [7:0] b);
    int k = 0;
    while (linefeed_n_i !== 1'b0 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
    drv <= b;
    ack_n_o <= 1'b0;
    k = 0;
    while (linefeed_n_i !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
    ack_n_o <= 1'b1;
    drv <= ~b;
  endtask
endmodule // ecppc_printer_model

// >>> dv/tb_ecp_parallel_port_control.sv
// Self-checking bench for the parallel port control block.
// Assumes the printer model and the design sources are compiled first.
`timescale 1ns/10ps
module tb_ecp_parallel_port_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [10:0] addr_i = 11'h000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic irq_line_i = 1'b0;
  logic [2:0] irq_sel_i = 3'h0;
  logic [7:0] rdata_o, pd_i, pd_o;
  logic pd_oe_n_o, strobe_pin_o, linefeed_pin_o, printer_reset_ctl_o, printer_select_pin_o;
  logic ack_n_i, busy_i, irq_o;
  int err_total = 0;
  int checked = 0;
  int irq_cnt = 0;
  ecppc_top uut (.clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .pd_i, .pd_o,
    .pd_oe_n_o, .strobe_pin_o, .linefeed_pin_o, .printer_reset_ctl_o, .printer_select_pin_o,
    .ack_n_i, .busy_i, .perror_i(1'b0), .select_i(1'b1), .fault_n_i(1'b1), .irq_line_i,
    .irq_sel_i, .irq_o);
  ecppc_printer_model pm (.clk_i, .strobe_n_i(strobe_pin_o), .linefeed_n_i(linefeed_pin_o),
    .dev_pd_i(pd_o), .dev_oe_n_i(pd_oe_n_o), .pd_o(pd_i), .ack_n_o(ack_n_i), .busy_o(busy_i));
  initial forever #12.5 clk_i = ~clk_i;
  // Interrupt pulses are counted here so no single cycle is missed
  always @(posedge clk_i) if (irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [10:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(n, {1'b0, e}, {1'b0, rdata_o});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Pin order: strobe, linefeed, initialise, select
  task automatic pins(input logic [3:0] e);
    settle(2);
    cmp("pins", {5'h00, e}, {5'h00, strobe_pin_o, linefeed_pin_o, printer_reset_ctl_o,
      printer_select_pin_o});
  endtask
  task automatic waitq(input int n);
    int k = 0;
    while (pm.got_q.size() < n && k < 600) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    pins(4'hd);
    rdc(11'h402, 8'h15, "ecr_reset");
    rdc(11'h002, 8'hc0, "dcr_reset");
  endtask
  task automatic t_dcr();
    wr(11'h002, 8'h3f);
    rdc(11'h002, 8'hff, "dcr_all");
    wr(11'h002, 8'h0a);
    pins(4'h8);
    wr(11'h002, 8'h05);
    pins(4'h7);
    wr(11'h002, 8'h00);
    rdc(11'h002, 8'hc0, "dcr_top");
  endtask
  task automatic t_dir();
    wr(11'h002, 8'h20);
    settle(2);
    cmp("oe_spp", 9'h000, {8'h00, pd_oe_n_o});
    wr(11'h402, 8'h34);
    settle(2);
    cmp("oe_ps2", 9'h001, {8'h00, pd_oe_n_o});
    wr(11'h402, 8'h14);
    wr(11'h002, 8'h00);
  endtask
  task automatic t_irq();
    irq_cnt = 0;
    wr(11'h002, 8'h10);
    pm.pulse_ack();
    settle(8);
    cmp("irq_on", 9'h001, 9'(irq_cnt));
    wr(11'h002, 8'h00);
    pm.pulse_ack();
    settle(8);
    cmp("irq_off", 9'h001, 9'(irq_cnt));
  endtask
  task automatic t_cfg();
    wr(11'h402, 8'hf4);
    rdc(11'h400, 8'h10, "cfg_a");
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_i);
      irq_sel_i <= 3'(s);
      irq_line_i <= s[0];
      settle(4);
      rdc(11'h401, {1'b0, s[0], 3'(s), 3'h7}, "cfg_b");
    end
    wr(11'h401, 8'h00);
    rdc(11'h401, 8'h7f, "cfg_b_low");
    wr(11'h402, 8'h14);
    rdc(11'h401, 8'h00, "cfg_b_hidden");
    rdc(11'h400, 8'h00, "cfg_a_hidden");
  endtask
  // Fill to refusal, then drain past empty
  task automatic t_test_fifo_port();
    wr(11'h402, 8'hd4);
    for (int i = 0; i < 16; i++) wr(11'h400, 8'h30 + 8'(i));
    rdc(11'h402, 8'hd6, "ecr_full");
    wr(11'h400, 8'hee);
    settle(1);
    cmp("test_strobe", 9'h001, {8'h00, strobe_pin_o});
    for (int i = 0; i < 16; i++) rdc(11'h400, 8'h30 + 8'(i), "test_fifo_port_data");
    rdc(11'h402, 8'hd5, "ecr_empty");
    rdc(11'h400, 8'h00, "test_fifo_port_under");
  endtask
  task automatic t_clear();
    wr(11'h400, 8'h11);
    wr(11'h400, 8'h22);
    wr(11'h402, 8'h14);
    rdc(11'h402, 8'h15, "ecr_spp");
    wr(11'h402, 8'hd4);
    rdc(11'h402, 8'hd5, "ecr_cleared");
  endtask
  task automatic t_std();
    wr(11'h402, 8'h54);
    pm.lag = 3;
    pm.got_q.delete();
    wr(11'h400, 8'ha5);
    wr(11'h400, 8'h5a);
    waitq(2);
    cmp("std_b0", 9'h0a5, pm.got_q[0]);
    cmp("std_b1", 9'h05a, pm.got_q[1]);
    cmp("std_width", 9'h014, 9'(pm.stb_w));
    settle(80);
  endtask
  // Slow peripheral: busy answers only after 30 cycles
  task automatic t_ecp_fwd();
    wr(11'h402, 8'h74);
    pm.lag = 30;
    pm.got_q.delete();
    wr(11'h400, 8'h3c);
    wr(11'h000, 8'hc3);
    waitq(2);
    cmp("ecp_data", 9'h03c, pm.got_q[0]);
    cmp("ecp_addr", 9'h1c3, pm.got_q[1]);
    settle(100);
  endtask
  task automatic t_ecp_rev();
    wr(11'h002, 8'h20);
    settle(2);
    cmp("oe_rev", 9'h001, {8'h00, pd_oe_n_o});
    pm.send_rev(8'h96);
    pm.send_rev(8'h69);
    settle(6);
    rdc(11'h400, 8'h96, "rev_b0");
    rdc(11'h400, 8'h69, "rev_b1");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang is cut off well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_dcr();
    t_dir();
    t_irq();
    t_cfg();
    t_test_fifo_port();
    t_clear();
    t_std();
    t_ecp_fwd();
    t_ecp_rev();
    print_verdict();
  end
endmodule // tb_ecp_parallel_port_control
